// ===== segdrv_pkg.sv
package segdrv_pkg;
   localparam int FRAME_BITS = 35;
   localparam int SEG_COUNT = 23;
   localparam int CNT_W = 6;
   // clock that makes the 36th edge of a frame
   localparam logic [CNT_W-1:0] LOAD_CLOCK = 6'h23;
   localparam real SCLK_MAX_MHZ = 0.5;
   // frame bit position (1..35) for each segment output 1..23
   localparam int SEG_POS [SEG_COUNT] = '{
      2, 3, 4, 5, 6, 7, 8,
      12, 13, 14, 15,
      20, 21, 22, 23, 24, 25,
      27,
      30, 31, 32, 33, 34};
endpackage

// ===== frame_if.sv
`timescale 1ns/1ps
interface frame_if;
   logic sclkRise;
   logic sclkFall;
   logic sdata;
   modport src (output sclkRise, output sclkFall, output sdata);
   modport dst (input sclkRise, input sclkFall, input sdata);
endinterface

// ===== link_sampler.sv
`timescale 1ns/1ps
module link_sampler
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pins
   input wire logic sclkPin,
   input wire logic sdataPin,
   // edges and data
   frame_if.src lnk
);
   logic [1:0] clkSync_r;
   logic [1:0] datSync_r;
   logic clkDly_r;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         clkSync_r <= 2'h0;
         datSync_r <= 2'h0;
         clkDly_r <= 1'b0;
      end
      else
      begin
         clkSync_r <= {clkSync_r[0], sclkPin};
         datSync_r <= {datSync_r[0], sdataPin};
         clkDly_r <= clkSync_r[1];
      end
   end
   assign lnk.sclkRise = clkSync_r[1] & ~clkDly_r;
   assign lnk.sclkFall = ~clkSync_r[1] & clkDly_r;
   assign lnk.sdata = datSync_r[1];
endmodule

// ===== serial_segment_display_driver.sv
`timescale 1ns/1ps
// Overview of operation
// - only data and clock, no load pin
// - 36th clock high latches 35 bits
// - following clock low clears shift stages
// - clear spares first stage master
// - power-on reset clears shifter and latches
// - start bit with clock resumes reception
// - output changes only on differing bit
// - 23 positions drive, 12 ignored
module serial_segment_display_driver
#(
   parameter int FRAME_BITS = segdrv_pkg::FRAME_BITS,
   parameter int SEG_COUNT = segdrv_pkg::SEG_COUNT
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial link
   input wire logic sclk,
   input wire logic sdata,
   // segment drive
   output logic [SEG_COUNT-1:0] segOut
);
   frame_if lnk ();

   link_sampler link_sampler_i
   (
      .clk(clk),
      .rst(rst),
      .sclkPin(sclk),
      .sdataPin(sdata),
      .lnk(lnk)
   );

   // a bit enters at stage 0 and climbs one stage per fall
   logic [FRAME_BITS:0] shift_r;
   logic masterFirst_r;
   logic [FRAME_BITS:1] latch_r;
   logic clearPend_r;
   logic [SEG_COUNT-1:0] segOut_r;
   logic loadNow;
   typedef logic [segdrv_pkg::CNT_W-1:0] cnt_t;
   cnt_t riseCnt_r;

   // stage that holds data bit k on the load rise
   function automatic int bit_stage(input int k);
      return FRAME_BITS - 1 - k;
   endfunction

   // start bit reached stage FRAME_BITS-1 on this rise
   assign loadNow = lnk.sclkRise & shift_r[FRAME_BITS-1];

   // master of stage 0 samples data on every rise
   always_ff @(posedge clk)
   begin
      if (rst)
         masterFirst_r <= 1'b0;
      else if (lnk.sclkRise)
         masterFirst_r <= lnk.sdata;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         shift_r <= '0;
      // clear on falling edge after load
      else if (lnk.sclkFall && clearPend_r)
         shift_r <= '0;
      else if (lnk.sclkFall)
         shift_r <= {shift_r[FRAME_BITS-1:0], masterFirst_r};
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         clearPend_r <= 1'b0;
      else if (loadNow)
         clearPend_r <= 1'b1;
      else if (lnk.sclkFall)
         clearPend_r <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         latch_r <= '0;
      else if (loadNow)
      begin
         // last bit is still at the pin on the load rise
         latch_r[FRAME_BITS] <= lnk.sdata;
         for (int k = 1; k < FRAME_BITS; k++)
            latch_r[k] <= shift_r[bit_stage(k)];
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         segOut_r <= '0;
      else
         for (int i = 0; i < SEG_COUNT; i++)
            segOut_r[i] <= latch_r[segdrv_pkg::SEG_POS[i]];
   end
   assign segOut = segOut_r;

   // rises counted from the start bit, for the checks below
   always_ff @(posedge clk)
   begin
      if (rst)
         riseCnt_r <= '0;
      else if (lnk.sclkFall && clearPend_r)
         riseCnt_r <= '0;
      else if (lnk.sclkRise && (riseCnt_r != '0 || lnk.sdata))
         riseCnt_r <= riseCnt_r + cnt_t'(1);
   end

   // a_load_on_rise: load only with a sampled rise
   a_load_on_rise:
   assert property (@(posedge clk) disable iff (rst)
      $changed(latch_r) |-> $past(lnk.sclkRise))
   else $error("latch changed without clock rise");

   // a_clear_after
   a_clear_after:
   assert property (@(posedge clk) disable iff (rst)
      (lnk.sclkFall && clearPend_r) |=> (shift_r == '0))
   else $error("shift stages not cleared after load");

   a_master_kept:
   assert property (@(posedge clk) disable iff (rst)
      (lnk.sclkFall && clearPend_r) |=> masterFirst_r == $past(masterFirst_r))
   else $error("first stage lost on clear");

   a_out_stable:
   assert property (@(posedge clk) disable iff (rst)
      $changed(segOut_r) |-> $past(latch_r) != $past(latch_r, 2))
   else $error("output changed without new latched bit");

   a_out_map:
   assert property (@(posedge clk) disable iff (rst)
      segOut_r[0] == $past(latch_r[2]) && segOut_r[7] == $past(latch_r[12]))
   else $error("low output mapping wrong");

   a_out_map_hi:
   assert property (@(posedge clk) disable iff (rst)
      segOut_r[17] == $past(latch_r[27])
      && segOut_r[22] == $past(latch_r[34]))
   else $error("high output mapping wrong");

   a_shift_move:
   assert property (@(posedge clk) disable iff (rst)
      (lnk.sclkFall && !clearPend_r)
      |=> shift_r[1] == $past(shift_r[0]))
   else $error("shift stage did not advance");

   a_reset_clear:
   assert property (@(posedge clk)
      $past(rst) |-> (shift_r == '0 && latch_r == '0))
   else $error("reset did not clear stages");

   a_load_at_36:
   assert property (@(posedge clk) disable iff (rst)
      loadNow |-> riseCnt_r == segdrv_pkg::LOAD_CLOCK)
   else $error("load not on the last clock of a frame");

   a_load_taken:
   assert property (@(posedge clk) disable iff (rst)
      (lnk.sclkRise && riseCnt_r == segdrv_pkg::LOAD_CLOCK) |-> loadNow)
   else $error("full frame did not load");

   a_latch_ends:
   assert property (@(posedge clk) disable iff (rst)
      loadNow |=> latch_r[FRAME_BITS] == $past(lnk.sdata)
      && latch_r[1] == $past(shift_r[FRAME_BITS-2]))
   else $error("latched bits out of order");

   a_seg_reset:
   assert property (@(posedge clk)
      rst |=> segOut_r == '0)
   else $error("reset did not clear outputs");

   a_clear_pend:
   assert property (@(posedge clk) disable iff (rst)
      loadNow |=> clearPend_r)
   else $error("no clear pending after load");

   a_pend_drop:
   assert property (@(posedge clk) disable iff (rst)
      (clearPend_r && lnk.sclkFall) |=> !clearPend_r)
   else $error("clear pending after the clear");

   a_count_restart:
   assert property (@(posedge clk) disable iff (rst)
      (lnk.sclkFall && clearPend_r) |=> riseCnt_r == '0)
   else $error("frame count not restarted");

   a_start_taken:
   assert property (@(posedge clk) disable iff (rst)
      (lnk.sclkFall && !clearPend_r && masterFirst_r) |=> shift_r[0])
   else $error("start bit not taken into first stage");

   a_edges_apart:
   assert property (@(posedge clk) disable iff (rst)
      !(lnk.sclkRise && lnk.sclkFall))
   else $error("rise and fall seen together");

   a_seg_steady:
   assert property (@(posedge clk) disable iff (rst)
      $stable(latch_r) |=> $stable(segOut_r))
   else $error("output moved with latch unchanged");

   a_master_idle:
   assert property (@(posedge clk) disable iff (rst)
      !lnk.sclkRise |=> $stable(masterFirst_r))
   else $error("first stage master changed without rise");
endmodule

// ===== frame_src.sv
`timescale 1ns/1ps
module frame_src
(
   // clock
   input wire logic clk,
   // pins
   output logic sclk,
   output logic sdata
);
   initial
   begin
      sclk = 1'h0;
      sdata = 1'h0;
   end
   // bench link runs at 8 MHz; logic needs 4 clk a phase
   task automatic half();
      #62.5;
   endtask
   // start one, then n-1 data bits
   task automatic send(input logic [35:1] d, input int n);
      for (int k = 0; k < n; k++)
      begin
         sdata <= (k == 0) ? 1'h1 : d[k];
         half();
         sclk <= 1'h1;
         half();
         sclk <= 1'h0;
      end
      sdata <= ~sdata;
      @(posedge clk);
   endtask
endmodule

// ===== serial_segment_display_driver_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
   $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module serial_segment_display_driver_bench;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic sclk;
   logic sdata;
   logic [22:0] segOut;
   logic [35:1] d;
   int n_fail = 0;
   int checks_done = 0;
   always #4 clk = ~clk;
   serial_segment_display_driver serial_segment_display_driver_i
   (.clk(clk), .rst(rst), .sclk(sclk), .sdata(sdata), .segOut(segOut));
   frame_src frame_src_i (.clk(clk), .sclk(sclk), .sdata(sdata));
   function automatic logic [22:0] seg(input logic [35:1] v);
      logic [22:0] e;
      for (int i = 0; i < 23; i++)
         e[i] = v[segdrv_pkg::SEG_POS[i]];
      return e;
   endfunction
   task automatic reset();
      rst <= 1'h1;
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      repeat (4) @(posedge clk);
   endtask
   task automatic frame(input logic [35:1] v, input logic [22:0] e);
      frame_src_i.send(v, 36);
      repeat (2) @(posedge clk);
      `CHK(segOut, e)
   endtask
   task automatic t_map();
      d = '1;
      frame(d, 23'h7FFFFF);
      for (int i = 0; i < 23; i++)
         d[segdrv_pkg::SEG_POS[i]] = 1'h0;
      frame(d, 23'h0);
      d = 35'h5_5555_5555;
      frame(d, seg(d));
      $display("map done");
   endtask
   task automatic t_b2b();
      frame_src_i.send(35'h7_FFFF_FFFF, 36);
      frame(35'h1_2345_6789, seg(35'h1_2345_6789));
      $display("b2b done");
   endtask
   task automatic t_hold();
      int moves = 0;
      logic [22:0] old;
      old = segOut;
      fork
         frame_src_i.send(35'h1_2345_6789, 36);
         repeat (600) @(posedge clk)
            if (segOut !== old) moves++;
      join
      `CHK(moves, 0)
      $display("hold done");
   endtask
   task automatic t_short();
      logic [22:0] old;
      old = segOut;
      frame_src_i.send(35'h0, 20);
      repeat (8) @(posedge clk);
      `CHK(segOut, old)
      reset();
      `CHK(segOut, 23'h0)
      frame(35'h0_0F0F_0F0F, seg(35'h0_0F0F_0F0F));
      $display("short done");
   endtask
   task automatic results();
      $display("checks %0d fails %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      reset();
      `CHK(segOut, 23'h0)
      t_map();
      t_b2b();
      t_hold();
      t_short();
      results();
   end
endmodule
